// ===== logic/csu_pkg.sv
/*
 * csu_pkg: constants, op codes and carrier structs of the compare and skip unit.
 * Assumes one core clock and a 32-bit AXI4-Lite slave.
 */
package csu_pkg;

    // operation codes of this slice
    typedef enum logic [2:0] {
        CSU_OP_CMP      = 3'h0,
        CSU_OP_CMP_CARRY = 3'h1,
        CSU_OP_CMP_IMM  = 3'h2,
        CSU_OP_SKIP_IF_REG_BIT_CLEAR = 3'h3,
        CSU_OP_SKIP_IF_REG_BIT_SET   = 3'h4,
        CSU_OP_SKIP_IF_IO_BIT_CLEAR  = 3'h5,
        CSU_OP_SKIP_IF_IO_BIT_SET    = 3'h6
    } csu_op_e;

    // sequencer states
    typedef enum logic [1:0] {
        CSU_ST_IDLE      = 2'h0,
        CSU_ST_SKIP_WORD = 2'h1,
        CSU_ST_SKIP_LAST = 2'h2
    } csu_state_e;

    // one instruction handed over by the core
    typedef struct packed {
        csu_op_e     op;
        logic [2:0]  bit_sel;
        logic [7:0]  dest_val;
        logic [7:0]  source_reg;
        logic [7:0]  imm_val;
        logic [5:0]  io_addr;
        logic [7:0]  io_val;
        logic        next_two_word;
        logic [15:0] program_counter;
    } csu_issue_s;

    // AXI4-Lite request channels toward the slave
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } csu_axil_req_s;

    // AXI4-Lite answer channels from the slave
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } csu_axil_rsp_s;

    // status flag positions
    localparam int unsigned CSU_FLAG_C = 0;
    localparam int unsigned CSU_FLAG_Z = 1;
    localparam int unsigned CSU_FLAG_N = 2;
    localparam int unsigned CSU_FLAG_V = 3;
    localparam int unsigned CSU_FLAG_H = 5;

    // register byte offsets
    localparam logic [7:0] CSU_OFS_CTRL     = 8'h00;
    localparam logic [7:0] CSU_OFS_STATUS   = 8'h04;
    localparam logic [7:0] CSU_OFS_LAST_PC  = 8'h08;
    localparam logic [7:0] CSU_OFS_COUNTS   = 8'h0C;

    // control fields and reset values
    localparam int unsigned CSU_CTRL_EN_BIT  = 0;
    localparam int unsigned CSU_CTRL_CLR_BIT = 1;
    localparam logic [31:0] CSU_CTRL_RST     = 32'h0000_0001;
    localparam logic [15:0] CSU_PC_RST       = 16'h0000;
    localparam logic [7:0]  CSU_FLAGS_RST    = 8'h00;

    // status fields
    localparam int unsigned CSU_STAT_FLAGS_LSB = 0;
    localparam int unsigned CSU_STAT_BUSY_BIT  = 8;
    localparam int unsigned CSU_STAT_TAKE_BIT  = 9;
    localparam int unsigned CSU_STAT_IO_LSB    = 16;

    // program counter steps
    localparam logic [15:0] CSU_PC_STEP_ONE   = 16'h0001;
    localparam logic [15:0] CSU_PC_STEP_TWO   = 16'h0002;
    localparam logic [15:0] CSU_PC_STEP_THREE = 16'h0003;

    // AXI responses
    localparam logic [1:0] CSU_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSU_RESP_SLVERR = 2'h2;

endpackage

// ===== logic/csu_cmp_alu.sv
/*
 * csu_cmp_alu: 8-bit subtract of the compare forms, used for flags only.
 * Assumes operands stable while the result is used.
 */
`timescale 1ns/1ps
`default_nettype none
module csu_cmp_alu
    import csu_pkg::*;
(
    // operands
    input  wire logic [7:0] dest_val,
    input  wire logic [7:0] sub_val,
    input  wire logic       carry_in,
    // status in and out
    input  wire logic [7:0] flags_in,
    output var  logic [7:0] flags_out
);
    logic [7:0] diff;

    always_comb begin
        diff = dest_val - sub_val - {7'h00, carry_in};
        flags_out = flags_in;
        flags_out[CSU_FLAG_Z] = (diff == 8'h00);
        flags_out[CSU_FLAG_N] = diff[7];
        flags_out[CSU_FLAG_V] = (dest_val[7] & ~sub_val[7] & ~diff[7])
                              | (~dest_val[7] & sub_val[7] & diff[7]);
        flags_out[CSU_FLAG_C] = (~dest_val[7] & sub_val[7]) | (sub_val[7] & diff[7])
                              | (diff[7] & ~dest_val[7]);
        flags_out[CSU_FLAG_H] = (~dest_val[3] & sub_val[3]) | (sub_val[3] & diff[3])
                              | (diff[3] & ~dest_val[3]);
    end
endmodule
`default_nettype wire

// ===== logic/csu_skip_eval.sv
/*
 * csu_skip_eval: tests one bit of a register or I/O value for a skip.
 * Assumes a skip op code when used.
 */
`timescale 1ns/1ps
`default_nettype none
module csu_skip_eval
    import csu_pkg::*;
(
    // operation
    input  wire csu_op_e    op,
    input  wire logic [2:0] bit_sel,
    // tested values
    input  wire logic [7:0] reg_val,
    input  wire logic [7:0] io_val,
    // decision
    output var  logic       take
);
    always_comb begin
        case (op)
            CSU_OP_SKIP_IF_REG_BIT_CLEAR: take = ~reg_val[bit_sel];
            CSU_OP_SKIP_IF_REG_BIT_SET:   take = reg_val[bit_sel];
            CSU_OP_SKIP_IF_IO_BIT_CLEAR:  take = ~io_val[bit_sel];
            CSU_OP_SKIP_IF_IO_BIT_SET:    take = io_val[bit_sel];
            default:                      take = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== logic/csu_compare_and_skip_unit.sv
/*
 * csu_compare_and_skip_unit: compare and conditional skip forms of an
 * 8-bit core, with AXI4-Lite control, status, last pc and counters.
 * Assumes the core takes the write pulses in the cycle they appear.
 */
// Chosen here: the register addresses and the AXI4-Lite register port.
// Summary of operation
// - register compare subtracts source from destination, keeps no result, sets five flags in one cycle.
// - compare with carry subtracts source and the current carry, sets five flags in one cycle.
// - compare immediate subtracts the instruction constant, keeps the register, sets flags in one cycle.
// - skip if register bit clear skips the next instruction when the bit is zero, flags untouched.
// - skip if register bit set skips the next instruction when the bit is one, flags untouched.
// - skip if I/O bit clear skips the next instruction when the I/O bit is zero, flags untouched.
// - skip if I/O bit set skips the next instruction when the I/O bit is one, flags untouched.
`timescale 1ns/1ps
`default_nettype none
module csu_compare_and_skip_unit
    import csu_pkg::*;
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // instruction issue from the core
    input  wire logic          issue_valid,
    input  wire csu_pkg::csu_issue_s issue,
    input  wire logic [7:0]    flags_in,
    output var  logic          issue_ready,
    // results to the core
    output var  logic [7:0]    flags_out,
    output var  logic          flags_we,
    output var  logic [15:0]   pc_out,
    output var  logic          pc_we,
    output var  logic          done,
    // register bus
    input  wire csu_pkg::csu_axil_req_s axil_req,
    output var  csu_pkg::csu_axil_rsp_s axil_rsp
);
    import csu_pkg::*;

    // decoding shared by issue and bookkeeping
    function automatic logic is_skip(input csu_op_e op);
        is_skip = op inside {[CSU_OP_SKIP_IF_REG_BIT_CLEAR:CSU_OP_SKIP_IF_IO_BIT_SET]};
    endfunction

    function automatic logic is_cmp(input csu_op_e op);
        is_cmp = (op == CSU_OP_CMP) || (op == CSU_OP_CMP_CARRY) || (op == CSU_OP_CMP_IMM);
    endfunction

    // execution state
    csu_state_e  state_r,    state_nxt;
    logic [7:0]  flags_r,    flags_nxt;
    logic        flags_we_r, flags_we_nxt;
    logic [15:0] pc_r,       pc_nxt;
    logic        pc_we_r,    pc_we_nxt;
    logic        done_r,     done_nxt;
    logic        ready_r,    ready_nxt;
    logic [15:0] target_r,   target_nxt;
    logic        take_r,     take_nxt;
    logic [5:0]  io_addr_r,  io_addr_nxt;
    logic [15:0] cmp_cnt_r,  cmp_cnt_nxt;
    logic [15:0] skip_cnt_r, skip_cnt_nxt;

    // bus state
    logic [31:0] ctrl_r,     ctrl_nxt;
    logic        aw_got_r,   aw_got_nxt;
    logic [7:0]  aw_addr_r,  aw_addr_nxt;
    logic        w_got_r,    w_got_nxt;
    logic [31:0] w_data_r,   w_data_nxt;
    logic [3:0]  w_strb_r,   w_strb_nxt;
    logic        bvalid_r,   bvalid_nxt;
    logic [1:0]  bresp_r,    bresp_nxt;
    logic        rvalid_r,   rvalid_nxt;
    logic [31:0] rdata_r,    rdata_nxt;
    logic [1:0]  rresp_r,    rresp_nxt;

    logic        issue_fire;
    logic [7:0]  sub_val;
    logic        carry_in;
    logic [7:0]  cmp_flags;
    logic        skip_take;
    logic        wr_fire;
    logic        clr_counts;

    assign issue_fire = issue_valid & ready_r;

    // compare operand selection
    always_comb begin
        sub_val  = issue.source_reg;
        carry_in = 1'b0;
        case (issue.op)
            CSU_OP_CMP_CARRY: begin
                carry_in = flags_in[CSU_FLAG_C];
            end
            CSU_OP_CMP_IMM: begin
                sub_val = issue.imm_val;
            end
            default: sub_val = issue.source_reg;
        endcase
    end

    csu_cmp_alu u_cmp (
        .dest_val  (issue.dest_val),
        .sub_val   (sub_val),
        .carry_in  (carry_in),
        .flags_in  (flags_in),
        .flags_out (cmp_flags)
    );

    csu_skip_eval u_skip (
        .op      (issue.op),
        .bit_sel (issue.bit_sel),
        .reg_val (issue.source_reg),
        .io_val  (issue.io_val),
        .take    (skip_take)
    );

    // sequencer
    always_comb begin
        state_nxt    = state_r;
        flags_nxt    = flags_r;
        flags_we_nxt = 1'b0;
        pc_nxt       = pc_r;
        pc_we_nxt    = 1'b0;
        done_nxt     = 1'b0;
        target_nxt   = target_r;
        take_nxt     = take_r;
        io_addr_nxt  = io_addr_r;
        cmp_cnt_nxt  = cmp_cnt_r;
        skip_cnt_nxt = skip_cnt_r;
        case (state_r)
            CSU_ST_IDLE: begin
                if (issue_fire && is_cmp(issue.op)) begin
                    flags_nxt    = cmp_flags;
                    flags_we_nxt = 1'b1;
                    pc_nxt       = issue.program_counter + CSU_PC_STEP_ONE;
                    pc_we_nxt    = 1'b1;
                    done_nxt     = 1'b1;
                    cmp_cnt_nxt  = cmp_cnt_r + 16'h0001;
                end else if (issue_fire && is_skip(issue.op)) begin
                    take_nxt    = skip_take;
                    io_addr_nxt = issue.io_addr;
                    if (!skip_take) begin
                        pc_nxt    = issue.program_counter + CSU_PC_STEP_ONE;
                        pc_we_nxt = 1'b1;
                        done_nxt  = 1'b1;
                    end else begin
                        target_nxt   = issue.program_counter + (issue.next_two_word
                                       ? CSU_PC_STEP_THREE : CSU_PC_STEP_TWO);
                        state_nxt    = issue.next_two_word ? CSU_ST_SKIP_WORD : CSU_ST_SKIP_LAST;
                        skip_cnt_nxt = skip_cnt_r + 16'h0001;
                    end
                end
            end
            CSU_ST_SKIP_WORD: begin
                state_nxt = CSU_ST_SKIP_LAST;
            end
            CSU_ST_SKIP_LAST: begin
                pc_nxt    = target_r;
                pc_we_nxt = 1'b1;
                done_nxt  = 1'b1;
                state_nxt = CSU_ST_IDLE;
            end
            default: begin
                state_nxt = CSU_ST_IDLE;
            end
        endcase
        if (clr_counts) begin
            cmp_cnt_nxt  = 16'h0000;
            skip_cnt_nxt = 16'h0000;
        end
        ready_nxt = ctrl_r[CSU_CTRL_EN_BIT] && (state_nxt == CSU_ST_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= CSU_ST_IDLE;
            flags_r    <= CSU_FLAGS_RST;
            flags_we_r <= 1'b0;
            pc_r       <= CSU_PC_RST;
            pc_we_r    <= 1'b0;
            done_r     <= 1'b0;
            ready_r    <= 1'b0;
            target_r   <= CSU_PC_RST;
            take_r     <= 1'b0;
            io_addr_r  <= 6'h00;
            cmp_cnt_r  <= 16'h0000;
            skip_cnt_r <= 16'h0000;
        end else begin
            state_r    <= state_nxt;
            flags_r    <= flags_nxt;
            flags_we_r <= flags_we_nxt;
            pc_r       <= pc_nxt;
            pc_we_r    <= pc_we_nxt;
            done_r     <= done_nxt;
            ready_r    <= ready_nxt;
            target_r   <= target_nxt;
            take_r     <= take_nxt;
            io_addr_r  <= io_addr_nxt;
            cmp_cnt_r  <= cmp_cnt_nxt;
            skip_cnt_r <= skip_cnt_nxt;
        end
    end

    assign issue_ready = ready_r;
    assign flags_out   = flags_r;
    assign flags_we    = flags_we_r;
    assign pc_out      = pc_r;
    assign pc_we       = pc_we_r;
    assign done        = done_r;

    // write path: address and data taken in either order
    assign wr_fire    = aw_got_r & w_got_r & ~bvalid_r;
    assign clr_counts = wr_fire && (aw_addr_r == CSU_OFS_CTRL) && w_strb_r[0]
                        && w_data_r[CSU_CTRL_CLR_BIT];

    always_comb begin
        aw_got_nxt  = aw_got_r;
        aw_addr_nxt = aw_addr_r;
        w_got_nxt   = w_got_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        ctrl_nxt    = ctrl_r;
        if (axil_req.awvalid && !aw_got_r) begin
            aw_got_nxt  = 1'b1;
            aw_addr_nxt = axil_req.awaddr;
        end
        if (axil_req.wvalid && !w_got_r) begin
            w_got_nxt  = 1'b1;
            w_data_nxt = axil_req.wdata;
            w_strb_nxt = axil_req.wstrb;
        end
        if (wr_fire) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = CSU_RESP_OKAY;
            case (aw_addr_r)
                CSU_OFS_CTRL: begin
                    if (w_strb_r[0]) begin
                        ctrl_nxt[CSU_CTRL_EN_BIT] = w_data_r[CSU_CTRL_EN_BIT];
                    end
                end
                CSU_OFS_STATUS, CSU_OFS_LAST_PC, CSU_OFS_COUNTS: bresp_nxt = CSU_RESP_OKAY;
                default: begin
                    bresp_nxt = CSU_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_r && axil_req.bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // read path: one read under way at a time
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (axil_req.arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = CSU_RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            case (axil_req.araddr)
                CSU_OFS_CTRL: begin
                    rdata_nxt[CSU_CTRL_EN_BIT] = ctrl_r[CSU_CTRL_EN_BIT];
                end
                CSU_OFS_STATUS: begin
                    rdata_nxt[CSU_STAT_FLAGS_LSB +: 8] = flags_r;
                    rdata_nxt[CSU_STAT_BUSY_BIT]       = (state_r != CSU_ST_IDLE);
                    rdata_nxt[CSU_STAT_TAKE_BIT]       = take_r;
                    rdata_nxt[CSU_STAT_IO_LSB +: 6]    = io_addr_r;
                end
                CSU_OFS_LAST_PC: begin
                    rdata_nxt[15:0] = pc_r;
                end
                CSU_OFS_COUNTS: begin
                    rdata_nxt = {skip_cnt_r, cmp_cnt_r};
                end
                default: begin
                    rresp_nxt = CSU_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && axil_req.rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r    <= CSU_CTRL_RST;
            aw_got_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_got_r   <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= CSU_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= CSU_RESP_OKAY;
        end else begin
            ctrl_r    <= ctrl_nxt;
            aw_got_r  <= aw_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_got_r   <= w_got_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // ready terms are flop outputs: low while a capture is held
    assign axil_rsp.awready = ~aw_got_r;
    assign axil_rsp.wready  = ~w_got_r;
    assign axil_rsp.bvalid  = bvalid_r;
    assign axil_rsp.bresp   = bresp_r;
    assign axil_rsp.arready = ~rvalid_r;
    assign axil_rsp.rvalid  = rvalid_r;
    assign axil_rsp.rdata   = rdata_r;
    assign axil_rsp.rresp   = rresp_r;
endmodule
`default_nettype wire

// ===== tb/csu_compare_and_skip_unit_assertions.sv
/*
 * csu_compare_and_skip_unit_assertions: port-level checks of the compare
 * and skip unit. Assumes it is bound to the unit's top module.
 */
`timescale 1ns/1ps
`default_nettype none
module csu_compare_and_skip_unit_assertions
    import csu_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // issue
    input  wire logic                   issue_valid,
    input  wire csu_pkg::csu_issue_s    issue,
    input  wire logic [7:0]             flags_in,
    input  wire logic                   issue_ready,
    // results
    input  wire logic [7:0]             flags_out,
    input  wire logic                   flags_we,
    input  wire logic [15:0]            pc_out,
    input  wire logic                   pc_we,
    input  wire logic                   done,
    // register bus
    input  wire csu_pkg::csu_axil_req_s axil_req,
    input  wire csu_pkg::csu_axil_rsp_s axil_rsp
);
    logic        fire, is_cmp, is_skip, tbit, want, take, borrow, zero, sign;
    logic [8:0]  diff;
    logic [15:0] pc_in;
    assign fire    = issue_valid && issue_ready;
    assign pc_in   = issue.program_counter;
    assign is_cmp  = issue.op inside {[CSU_OP_CMP:CSU_OP_CMP_IMM]};
    assign is_skip = issue.op inside {[CSU_OP_SKIP_IF_REG_BIT_CLEAR:CSU_OP_SKIP_IF_IO_BIT_SET]};
    assign tbit    = (issue.op < CSU_OP_SKIP_IF_IO_BIT_CLEAR)
                     ? issue.source_reg[issue.bit_sel] : issue.io_val[issue.bit_sel];
    assign want    = issue.op inside {CSU_OP_SKIP_IF_REG_BIT_SET, CSU_OP_SKIP_IF_IO_BIT_SET};
    assign take    = is_skip && (tbit == want);
    // borrow-extended difference of the compare forms
    assign diff    = {1'b0, issue.dest_val}
                     - {1'b0, (issue.op == CSU_OP_CMP_IMM) ? issue.imm_val : issue.source_reg}
                     - {8'h00, (issue.op == CSU_OP_CMP_CARRY) & flags_in[CSU_FLAG_C]};
    assign borrow  = diff[8];
    assign zero    = (diff[7:0] == 8'h00);
    assign sign    = diff[7];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cmp_one_cycle_a: assert property (
        fire && is_cmp |=> flags_we && pc_we && done && pc_out == $past(pc_in) + CSU_PC_STEP_ONE)
        else $error("compare did not finish in one cycle");
    cmp_carry_flag_a: assert property (
        fire && is_cmp |=> flags_out[CSU_FLAG_C] == $past(borrow))
        else $error("compare carry flag wrong");
    cmp_zero_flag_a: assert property (
        fire && is_cmp |=> flags_out[CSU_FLAG_Z] == $past(zero))
        else $error("compare zero flag wrong");
    cmp_neg_flag_a: assert property (
        fire && is_cmp |=> flags_out[CSU_FLAG_N] == $past(sign))
        else $error("compare negative flag wrong");
    skip_no_flags_a: assert property (
        fire && is_skip |=> !flags_we)
        else $error("skip wrote the flags");
    skip_untaken_a: assert property (
        fire && is_skip && !take |=> done && pc_we && pc_out == $past(pc_in) + CSU_PC_STEP_ONE)
        else $error("untaken skip wrong");
    skip_one_word_a: assert property (
        fire && take && !issue.next_two_word |=> (!done && !issue_ready)
        ##1 (done && pc_out == $past(pc_in, 2) + CSU_PC_STEP_TWO))
        else $error("taken skip over one word wrong");
    skip_two_word_a: assert property (
        fire && take && issue.next_two_word |=> (!done && !pc_we)[*2]
        ##1 (done && pc_out == $past(pc_in, 3) + CSU_PC_STEP_THREE))
        else $error("taken skip over two words wrong");
    bresp_hold_a: assert property (
        axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (
        axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read answer late");
endmodule

bind csu_compare_and_skip_unit csu_compare_and_skip_unit_assertions
    i_csu_compare_and_skip_unit_assertions (.aclk(aclk), .aresetn(aresetn),
    .issue_valid(issue_valid), .issue(issue), .flags_in(flags_in), .issue_ready(issue_ready),
    .flags_out(flags_out), .flags_we(flags_we), .pc_out(pc_out), .pc_we(pc_we), .done(done),
    .axil_req(axil_req), .axil_rsp(axil_rsp));
`default_nettype wire

// ===== tb/csu_compare_and_skip_unit_tb_top.sv
/*
 * csu_compare_and_skip_unit_tb_top: self-checking bench of the unit.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module csu_compare_and_skip_unit_tb_top;
    import csu_pkg::*;
    logic          aclk, aresetn, issue_valid, issue_ready, flags_we, pc_we, done;
    csu_issue_s    issue;
    logic [7:0]    flags_in, flags_out;
    logic [15:0]   pc_out;
    csu_axil_req_s axil_req;
    csu_axil_rsp_s axil_rsp;
    int            err_total, check_count, cmp_n, tk_n;
    logic [31:0]   rd;
    logic [1:0]    rr;

    csu_compare_and_skip_unit i_csu_compare_and_skip_unit (.aclk(aclk), .aresetn(aresetn),
        .issue_valid(issue_valid), .issue(issue), .flags_in(flags_in),
        .issue_ready(issue_ready), .flags_out(flags_out), .flags_we(flags_we),
        .pc_out(pc_out), .pc_we(pc_we), .done(done), .axil_req(axil_req),
        .axil_rsp(axil_rsp));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 50) begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic ha, hw, pa, pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        axil_req.awaddr  <= a;
        axil_req.awvalid <= 1'b1;
        axil_req.wdata   <= d;
        axil_req.wstrb   <= 4'hF;
        axil_req.wvalid  <= 1'b1;
        axil_req.bready  <= 1'b1;
        do begin
            @(negedge aclk);
            ha = pa && axil_rsp.awready === 1'b1;
            hw = pw && axil_rsp.wready === 1'b1;
            @(posedge aclk);
            if (ha) axil_req.awvalid <= 1'b0;
            if (hw) axil_req.wvalid <= 1'b0;
            pa &= !ha;
            pw &= !hw;
            n++;
        end while ((pa || pw) && n < 50);
        do begin @(negedge aclk); n++; end while (axil_rsp.bvalid !== 1'b1 && n < 50);
        tmo(n);
        chk(32'(axil_rsp.bresp), 32'(er));
        @(posedge aclk);
        axil_req.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        axil_req.araddr  <= a;
        axil_req.arvalid <= 1'b1;
        axil_req.rready  <= 1'b1;
        do begin @(negedge aclk); n++; end while (axil_rsp.arready !== 1'b1 && n < 50);
        @(posedge aclk);
        axil_req.arvalid <= 1'b0;
        do begin @(negedge aclk); n++; end while (axil_rsp.rvalid !== 1'b1 && n < 50);
        tmo(n);
        rd = axil_rsp.rdata;
        rr = axil_rsp.rresp;
        @(posedge aclk);
        axil_req.rready <= 1'b0;
    endtask

    // issues one instruction, counts cycles from take to done
    task automatic do_op(input csu_issue_s it, input logic [7:0] fl, output int cyc,
                         output logic fw);
        int n;
        n = 0;
        fw = 1'b0;
        @(posedge aclk);
        issue       <= it;
        flags_in    <= fl;
        issue_valid <= 1'b1;
        do begin @(negedge aclk); n++; end while (issue_ready !== 1'b1 && n < 50);
        tmo(n);
        @(posedge aclk);
        issue_valid <= 1'b0;
        cyc = 0;
        do begin
            @(negedge aclk);
            cyc++;
            fw |= (flags_we === 1'b1);
        end while (done !== 1'b1 && cyc < 50);
        tmo(cyc);
    endtask

    task automatic t_cmp();
        csu_issue_s it;
        logic [7:0] a, o, r, e;
        logic [4:0] hb;
        logic       ci, fw;
        int         cyc;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 4; i++) begin
                a = 8'(32'h7F108000 >> (8 * i));
                o = 8'(32'hFF010100 >> (8 * i));
                ci = (k == 1) && i[0];
                it = '0;
                it.op = csu_op_e'(k);
                it.dest_val = a;
                it.source_reg = (k == 2) ? 8'hA5 : o;
                it.imm_val = (k == 2) ? o : 8'h5A;
                it.program_counter = 16'h0100 + 16'(i);
                e = 8'hD0;
                {e[CSU_FLAG_C], r} = {1'b0, a} - {1'b0, o} - 9'(ci);
                hb = {1'b0, a[3:0]} - {1'b0, o[3:0]} - 5'(ci);
                e[CSU_FLAG_Z] = (r == 8'h00);
                e[CSU_FLAG_N] = r[7];
                e[CSU_FLAG_V] = (a[7] ^ o[7]) & (r[7] ^ a[7]);
                e[CSU_FLAG_H] = hb[4];
                do_op(it, 8'hD0 | 8'(i[0]), cyc, fw);
                chk(cyc, 1);
                chk(32'(flags_out), 32'(e));
                chk(32'(pc_out), 32'(it.program_counter + 16'h0001));
                cmp_n++;
            end
        end
    endtask

    task automatic t_skip();
        csu_issue_s it;
        logic [7:0] v;
        logic [2:0] bs;
        logic       tk, fw;
        int         cyc, e;
        for (int k = 3; k < 7; k++) begin
            for (int j = 0; j < 4; j++) begin
                bs = 3'((k + j) % 8);
                v = j[0] ? (8'h01 << bs) : ~(8'h01 << bs);
                it = '0;
                it.op = csu_op_e'(k);
                it.bit_sel = bs;
                it.source_reg = (k < 5) ? v : ~v;
                it.io_val = (k < 5) ? ~v : v;
                it.io_addr = 6'(k * 5 + j);
                it.next_two_word = j[1];
                it.program_counter = 16'hFFFE;
                tk = (j[0] == (k == 4 || k == 6));
                e = tk ? (j[1] ? 3 : 2) : 1;
                do_op(it, 8'h3F, cyc, fw);
                chk(cyc, e);
                chk(32'(pc_out), {16'h0, 16'hFFFE + 16'(e)});
                chk(32'(fw), 0);
                tk_n += int'(tk);
            end
        end
    endtask

    task automatic t_regs();
        axi_rd(CSU_OFS_CTRL);
        chk(rd, CSU_CTRL_RST);
        axi_rd(CSU_OFS_COUNTS);
        chk(rd, {tk_n[15:0], cmp_n[15:0]});
        axi_rd(CSU_OFS_STATUS);
        chk(32'(rd[21:8]), 32'h2102);
        axi_rd(8'h10);
        chk(32'(rr), 32'(CSU_RESP_SLVERR));
        axi_wr(8'h14, 32'h0, CSU_RESP_SLVERR);
        axi_wr(CSU_OFS_CTRL, 32'h0, CSU_RESP_OKAY);
        @(negedge aclk);
        chk(32'(issue_ready), 0);
        axi_wr(CSU_OFS_CTRL, 32'h3, CSU_RESP_OKAY);
        axi_rd(CSU_OFS_COUNTS);
        chk(rd, 0);
    endtask

    initial begin
        aresetn = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        flags_in = 8'h00;
        axil_req = '0;
        err_total = 0;
        check_count = 0;
        cmp_n = 0;
        tk_n = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_cmp();
        t_skip();
        t_regs();
        wrap_up();
    end
endmodule
`default_nettype wire
